/* rtl/adc_serial_readout.sv */
// Conversion start and serial readout of a 16-bit sampling converter
//
// Behaviour
// - Convert strobe rise starts conversion, latches mode
// - Select mode: strobe low drives serial output
// - Result leaves on serial pin, shift-clock timed
// - Each selected shift-clock fall advances result one bit
// - Daisy input low at strobe rise: chain
// - Chain mode: daisy input is serial data
// - Daisy bit reappears after sixteen shift clocks
// - Daisy input high at strobe rise: select
// - Select mode: strobe or daisy low enables
// - Select mode: low select at conversion end arms busy
// - Result ready within 1.6 us of start
// - Select mode without busy: bit 15 appears first
// - Select mode: release on deselect or last
// - Straight binary, saturating at all ones on overrange
`timescale 1ns/100ps
module adc_serial_readout (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Host pins
  input  wire logic        convert_strobe_i,
  input  wire logic        shift_clock_i,
  input  wire logic        mode_select_daisy_in_i,
  // Converter core sample, already straight binary
  input  wire logic [16:0] sample_i,
  // Serial result pin, three-state as output and enable
  output logic             serial_result_out_o,
  output logic             serial_result_oe_o,
  // Status
  output logic             chain_mode_o,
  output logic             busy_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  pin_sync #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    // Daisy goes in inverted so the cleared stages read its high idle level
    .pin_i   ({~mode_select_daisy_in_i, shift_clock_i, convert_strobe_i}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  logic cnv_lvl;
  logic cnv_rise;
  logic sck_rise;
  logic sck_fall;
  logic sdi_lvl;

  assign cnv_lvl  = pin_lvl[0];
  assign cnv_rise = pin_rise[0];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign sdi_lvl  = ~pin_lvl[2];  // Undo the inversion: idle high after reset

  // ----------------------------------------------------------------
  // Saturating code from the core sample
  // ----------------------------------------------------------------
  // Bit 16 of the sample flags overrange; a raw signed view is not used here
  logic [15:0] sat_code;

  always_comb begin
    if (sample_i[16]) begin
      sat_code = conv_pkg::CODE_MAX;
    end else begin
      sat_code = sample_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  conv_pkg::phase_e phase_r;
  conv_pkg::phase_e phase_nxt;
  logic [4:0]       conv_cnt_r;
  logic [4:0]       conv_cnt_nxt;
  logic             chain_r;
  logic             chain_nxt;
  logic [15:0]      shreg_r;
  logic [15:0]      shreg_nxt;
  logic [4:0]       bit_cnt_r;
  logic [4:0]       bit_cnt_nxt;
  logic             sdo_r;
  logic             sdo_nxt;
  logic             oe_r;
  logic             oe_nxt;
  logic             busy_r;
  logic             busy_nxt;
  logic             done_r;
  logic             done_nxt;

  logic selected;
  logic conv_end;

  // Select mode is enabled by either low level; chain mode reads while high
  always_comb begin
    if (chain_r) begin
      selected = cnv_lvl;
    end else begin
      selected = ~cnv_lvl | ~sdi_lvl;
    end
  end

  assign conv_end = (phase_r == conv_pkg::PH_CONV) && (conv_cnt_r == conv_pkg::CONV_LAST);

  // ----------------------------------------------------------------
  // Conversion phase and mode latch
  // ----------------------------------------------------------------
  // Restarting mid-conversion is allowed: a new rise simply begins again
  always_comb begin
    phase_nxt    = phase_r;
    conv_cnt_nxt = conv_cnt_r;
    chain_nxt    = chain_r;
    case (phase_r)
      conv_pkg::PH_IDLE: begin
        conv_cnt_nxt = '0;
      end
      conv_pkg::PH_CONV: begin
        if (conv_end) begin
          phase_nxt = conv_pkg::PH_IDLE;
        end else begin
          conv_cnt_nxt = conv_cnt_r + 5'h01;
        end
      end
      default: begin
        phase_nxt = conv_pkg::PH_IDLE;
      end
    endcase
    if (cnv_rise) begin
      phase_nxt    = conv_pkg::PH_CONV;
      conv_cnt_nxt = '0;
      chain_nxt    = ~sdi_lvl;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_r    <= conv_pkg::PH_IDLE;
      conv_cnt_r <= '0;
      chain_r    <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      chain_r    <= chain_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Shift path
  // ----------------------------------------------------------------
  // Loading at conversion end presents bit 15 at once, so the host's first
  // capture edge already sees the MSB when busy is not armed
  always_comb begin
    shreg_nxt   = shreg_r;
    bit_cnt_nxt = bit_cnt_r;
    sdo_nxt     = sdo_r;
    oe_nxt      = oe_r;
    busy_nxt    = busy_r;
    done_nxt    = done_r;
    if (cnv_rise) begin
      done_nxt    = 1'b0;
      busy_nxt    = 1'b0;
      bit_cnt_nxt = conv_pkg::BIT_CNT_0;
    end else if (conv_end) begin
      shreg_nxt   = sat_code;
      sdo_nxt     = sat_code[15];
      bit_cnt_nxt = conv_pkg::BIT_CNT_0;
      done_nxt    = 1'b1;
      busy_nxt    = ~chain_r & selected;
    end else if (done_r && sck_fall && selected) begin
      if (chain_r) begin
        // Daisy bit enters at the bottom, reaches the pin 15 falls later
        sdo_nxt   = shreg_r[14];
        shreg_nxt = {shreg_r[14:0], sdi_lvl};
      end else begin
        sdo_nxt   = shreg_r[14];
        shreg_nxt = {shreg_r[14:0], 1'b0};
      end
      busy_nxt = 1'b0;
      if (bit_cnt_r != conv_pkg::BIT_CNT_N) begin
        bit_cnt_nxt = bit_cnt_r + 5'h01;
      end
    end
    // Chain mode always drives; select mode follows selection and drops after the last fall
    if (chain_r) begin
      oe_nxt = 1'b1;
    end else begin
      oe_nxt = selected && (bit_cnt_nxt != conv_pkg::BIT_CNT_N);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shreg_r   <= conv_pkg::RESULT_RST;
      bit_cnt_r <= conv_pkg::BIT_CNT_0;
      sdo_r     <= 1'b0;
      oe_r      <= 1'b0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      shreg_r   <= shreg_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sdo_r     <= sdo_nxt;
      oe_r      <= oe_nxt;
      busy_r    <= busy_nxt;
      done_r    <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Busy is armed at conversion end; the pin is then held low until the first selected fall
  assign serial_result_out_o = busy_r ? 1'b0 : sdo_r;
  assign serial_result_oe_o  = oe_r;
  assign chain_mode_o        = chain_r;
  assign busy_o              = busy_r;

  // Rising shift edges are not used: data changes only on falls
  logic unused_rise;
  assign unused_rise = sck_rise;

endmodule : adc_serial_readout

/* rtl/conv_pkg.sv */
// Constants shared by the converter serial readout logic
package conv_pkg;

  // ----------------------------------------------------------------
  // Result word
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_W   = 16;
  localparam logic [15:0] CODE_MAX   = 16'hffff;
  localparam logic [15:0] CODE_MIN   = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned CONV_TIME_NS   = 1600;  // 1.6 us longest conversion
  // Longest time rounds down, never below one cycle
  localparam int unsigned CONV_CYC_RAW   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES    = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int unsigned CONV_CNT_W     = 5;
  localparam logic [4:0]  CONV_LAST      = 5'(CONV_CYCLES - 1);

  // ----------------------------------------------------------------
  // Bit counter
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CNT_W  = 5;
  localparam logic [4:0]  BIT_CNT_0  = 5'h00;
  localparam logic [4:0]  BIT_CNT_N  = 5'h10;

  // ----------------------------------------------------------------
  // Converter phases, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_CONV = 2'b10
  } phase_e;

endpackage : conv_pkg

/* rtl/pin_sync.sv */
// Two-stage synchroniser with edge detection for outside pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Raw pins and synchronised view
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges come from the settled stages only
  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;

endmodule : pin_sync

/* bench/adc_serial_readout_checker.sv */
// Pin properties of the converter serial readout
`timescale 1ns/100ps
module adc_serial_readout_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // Watched pins
  input wire logic        convert_strobe_i,
  input wire logic        shift_clock_i,
  input wire logic        mode_select_daisy_in_i,
  input wire logic        serial_result_out_o,
  input wire logic        serial_result_oe_o,
  input wire logic        chain_mode_o,
  input wire logic        busy_o
);
  logic        shift_q_r;
  logic [5:0]  falls_r;
  logic [15:0] hist_r;
  // Falls and daisy levels since the strobe rise; the count is not reloaded mid-frame
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q_r <= 1'b0;
      falls_r   <= 6'h00;
      hist_r    <= 16'h0000;
    end else begin
      shift_q_r <= shift_clock_i;
      if ($rose(convert_strobe_i)) falls_r <= 6'h00;
      else if (shift_q_r && !shift_clock_i) begin
        falls_r <= falls_r + 6'h01;
        hist_r  <= {hist_r[14:0], mode_select_daisy_in_i};
      end
    end
  end
  // Pins pass a synchroniser, so the daisy level is held seven samples
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence rise_chain_s;
    $rose(convert_strobe_i) ##0 (convert_strobe_i && !mode_select_daisy_in_i)[*7];
  endsequence
  sequence rise_sel_s;
    $rose(convert_strobe_i) ##0 (convert_strobe_i && mode_select_daisy_in_i)[*7];
  endsequence
  chain_latch_a:
    assert property (rise_chain_s |-> chain_mode_o) else $error("chain not taken");
  sel_latch_a:
    assert property (rise_sel_s |-> !chain_mode_o) else $error("select not taken");
  oe_release_a:
    assert property ((!chain_mode_o && convert_strobe_i && mode_select_daisy_in_i)[*6]
      |-> !serial_result_oe_o) else $error("pin not released");
  chain_drive_a:
    assert property (chain_mode_o && $past(chain_mode_o) |-> serial_result_oe_o)
      else $error("chain pin idle");
  busy_low_a:
    assert property (busy_o |-> !serial_result_out_o) else $error("busy pin high");
  busy_mode_a:
    assert property (busy_o |-> !chain_mode_o) else $error("busy in chain");
  bit_stands_a:
    assert property (shift_clock_i[*4] |-> $stable(serial_result_out_o))
      else $error("bit moved");
  daisy_delay_a:
    assert property ((chain_mode_o && falls_r > 6'h0f && shift_clock_i)[*3]
      |-> serial_result_out_o == hist_r[15]) else $error("daisy bit wrong");
endmodule : adc_serial_readout_checker

/* bench/host_model.sv */
// Host model driving strobe, shift clock and daisy data
`timescale 1ns/100ps
module host_model (
  // Clock and returned data
  input  wire logic clk_i,
  input  wire logic serial_result_out_i,
  // Pins toward the converter
  output logic      convert_strobe_o,
  output logic      shift_clock_o,
  output logic      mode_select_daisy_in_o
);
  // Idle levels; the shift clock is parked low between frames
  initial begin
    convert_strobe_o       = 1'b0;
    shift_clock_o          = 1'b0;
    mode_select_daisy_in_o = 1'b1;
  end
  // Strobe and daisy change together, just after a falling clock edge
  task automatic pins(input logic strobe, input logic daisy);
    @(negedge clk_i);
    convert_strobe_o       = strobe;
    mode_select_daisy_in_o = daisy;
  endtask : pins
  // Rise with the mode on daisy, then wait out 1.6 us plus sync delay
  task automatic start(input logic chain);
    pins(1'b0, !chain);
    pins(1'b1, !chain);
    repeat (24) @(negedge clk_i);
    mode_select_daisy_in_o = 1'b1;
  endtask : start
  // Frame of 800 ns clocks; data taken before each rise, daisy set after each rise
  task automatic frame(input int n, input logic [15:0] din, output logic [31:0] got);
    got = 32'h0;
    for (int k = 0; k < n; k++) begin
      repeat (4) @(negedge clk_i);
      got                    = {got[30:0], serial_result_out_i};
      shift_clock_o          = 1'b1;
      mode_select_daisy_in_o = din[4'(15 - k)];
      repeat (4) @(negedge clk_i);
      shift_clock_o          = 1'b0;
    end
  endtask : frame
endmodule : host_model

/* bench/test_adc_serial_readout.sv */
// Self-checking bench of the converter serial readout
`timescale 1ns/100ps
module test_adc_serial_readout;
  logic        clk_i;
  logic        reset_i;
  logic        convert_strobe_i;
  logic        shift_clock_i;
  logic        mode_select_daisy_in_i;
  logic [16:0] sample_i;
  logic        serial_result_out_o;
  logic        serial_result_oe_o;
  logic        chain_mode_o;
  logic        busy_o;
  logic [31:0] got;
  int          fail_count;
  int          checks;
  adc_serial_readout i_adc_serial_readout (.clk_i, .reset_i, .convert_strobe_i,
    .shift_clock_i, .mode_select_daisy_in_i, .sample_i, .serial_result_out_o,
    .serial_result_oe_o, .chain_mode_o, .busy_o);
  host_model i_host_model (.clk_i, .serial_result_out_i(serial_result_out_o),
    .convert_strobe_o(convert_strobe_i), .shift_clock_o(shift_clock_i),
    .mode_select_daisy_in_o(mode_select_daisy_in_i));
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  // Case inequality so an unknown never passes
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Reset for eight cycles with pins parked at their idle levels, so no false
  // strobe edge follows; outputs sit low in reset, then strobe low drives
  task automatic do_reset;
    i_host_model.pins(1'b0, 1'b1);
    reset_i = 1'b1;
    tick(8);
    check({serial_result_oe_o, chain_mode_o, busy_o}, 3'b000);
    reset_i = 1'b0;
    tick(2);
    check({serial_result_oe_o, chain_mode_o, busy_o}, 3'b100);
  endtask : do_reset
  // Select mode: daisy low or strobe low enables, MSB shows first
  task automatic t_select;
    sample_i = 17'h0a5c3;
    i_host_model.start(1'b0);
    check(serial_result_oe_o, 1'b0);
    i_host_model.pins(1'b1, 1'b0);
    tick(8);
    check({serial_result_oe_o, serial_result_out_o}, 2'b11);
    i_host_model.pins(1'b1, 1'b1);
    tick(8);
    check(serial_result_oe_o, 1'b0);
    i_host_model.pins(1'b0, 1'b1);
    tick(8);
    check(serial_result_oe_o, 1'b1);
    $display("select enables done");
  endtask : t_select
  // Back-to-back readouts; overrange must saturate to all ones
  task automatic t_range;
    logic [16:0] s [3] = '{17'h0a5c3, 17'h10000, 17'h00000};
    for (int k = 0; k < 3; k++) begin
      sample_i = s[k];
      i_host_model.start(1'b0);
      i_host_model.pins(1'b0, 1'b1);
      tick(8);
      i_host_model.frame(16, 16'hffff, got);
      check(got[15:0], s[k][16] ? 16'hffff : s[k][15:0]);
      tick(8);
      check(serial_result_oe_o, 1'b0);
    end
    $display("range readout done");
  endtask : t_range
  // Chain mode: own word, then the upstream word sixteen clocks later
  task automatic t_chain;
    sample_i = 17'h03c5a;
    i_host_model.start(1'b1);
    check({chain_mode_o, serial_result_oe_o}, 2'b11);
    i_host_model.frame(32, 16'h9e17, got);
    check(got, 32'h3c5a9e17);
    $display("chain readout done");
  endtask : t_chain
  // Selected while converting: busy armed and pin held low
  task automatic t_busy;
    sample_i = 17'h0ffff;
    i_host_model.pins(1'b0, 1'b1);
    tick(8);
    i_host_model.pins(1'b1, 1'b1);
    tick(8);
    i_host_model.pins(1'b0, 1'b1);
    tick(24);
    check({busy_o, serial_result_out_o, chain_mode_o}, 3'b100);
    $display("busy flag done");
  endtask : t_busy
  // Scenario order, with a reset before the busy case
  initial begin
    fail_count = 0;
    checks     = 0;
    sample_i   = 17'h00000;
    do_reset();
    t_select();
    t_range();
    t_chain();
    do_reset();
    t_busy();
    close_out();
  end
endmodule : test_adc_serial_readout
bind adc_serial_readout adc_serial_readout_checker i_adc_serial_readout_checker (.clk_i,
  .reset_i, .convert_strobe_i, .shift_clock_i, .mode_select_daisy_in_i,
  .serial_result_out_o, .serial_result_oe_o, .chain_mode_o, .busy_o);
